/* hw/hid_device.sv */
// Function
// - Reset, then detect link before any transaction
// - Straps: select high I2C, else address pin
// - SPI roles: NSS, MISO, MOSI, SCK
// - UART roles: receive, transmit, auxiliary, request
// - I2C roles: SCL and address inputs
// - SPI rate limited to 10 Mbit/s
// - Device is slave, never drives SCK
// - Bytes shift most significant bit first
// - MOSI changes falling, sampled rising
// - Device updates MISO on falling edge
// - First byte gives direction and address
// - Read burst: data follows each address
// - Write burst: one address, many data
// - MSB one means read, address bits 6..1
// - MSB zero means write, same address
`timescale 1ns/1ps
module hid_device (
  input  wire logic             clk,        // System clock
  input  wire logic             rst_b,      // Synchronous reset, active low
  hid_link_if.dev               link,       // Pins toward the host
  output hid_pkg::hid_link_e    linkSel,    // Detected host link
  output logic                  wrStrobe,   // Register write pulse
  output logic [5:0]            wrAddr,     // Register write address
  output logic [7:0]            wrData,     // Register write data
  output logic                  rdReq,      // Register read pulse
  output logic [5:0]            rdAddr,     // Register read address
  input  wire logic [7:0]       rdData,     // Read data, in the same cycle as rdReq
  output logic                  uartRx,     // Filtered UART receive level
  input  wire logic             uartTx,     // UART transmit level to drive
  input  wire logic             uartAux,    // UART auxiliary level to drive
  input  wire logic             uartRts,    // UART request-to-send level
  output logic [6:0]            i2cAddr     // Latched I2C slave address bits
);
  import hid_pkg::*;

  typedef enum logic [0:0] {
    D_WAIT,
    D_RUN
  } hid_dphase_e;

  typedef struct packed {
    hid_dphase_e      phase;
    logic [3:0]       settle;
    hid_link_e        link;
    logic [6:0]       i2cAddr;
    logic [NSYNC-1:0] s0;
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
    logic [NSYNC-1:0] filt;
    logic [2:0]       bitCnt;
    logic             firstByte;
    logic             isRead;
    logic [5:0]       addr;
    logic [7:0]       rxSh;
    logic [7:0]       txSh;
    logic [7:0]       nextTx;
    logic             rdPend;
    logic             wrStrobe;
    logic [5:0]       wrAddr;
    logic [7:0]       wrData;
    logic             rdReq;
    logic [5:0]       rdAddr;
    logic             p7;
    logic             p7Oe;
    logic             p6;
    logic             p6Oe;
    logic             p5;
    logic             p5Oe;
    logic             uartRx;
  } hid_dev_s;

  hid_dev_s q;
  hid_dev_s n;

  // Next-state logic for the whole port
  always_comb begin
    logic       rise;
    logic       fall;
    logic       nssLow;
    logic       mosi;
    logic [7:0] byteIn;
    logic       wantRead;
    rise     = 1'b0;
    fall     = 1'b0;
    nssLow   = 1'b0;
    mosi     = 1'b0;
    byteIn   = 8'h00;
    wantRead = 1'b0;
    n          = q;
    n.wrStrobe = 1'b0;
    n.rdReq    = 1'b0;

    // Three-stage synchronisers; a level counts once stages two and three agree.
    // Sampling SCK costs several clocks, so this port reaches far less than
    // the full link rate at this clock; the host end is slowed to match.
    n.s0 = {link.lowPins, link.pin5, link.pin6, link.extAddr, link.i2cSel, link.hostSdata};
    n.s1 = q.s0;
    n.s2 = q.s1;
    for (int i = 0; i < NSYNC; i++) begin
      if (q.s1[i] == q.s2[i]) begin
        n.filt[i] = q.s2[i];
      end
    end
    rise   = ~q.filt[SY_PIN5] & n.filt[SY_PIN5];
    fall   = q.filt[SY_PIN5] & ~n.filt[SY_PIN5];
    nssLow = ~n.filt[SY_SDATA];
    mosi   = n.filt[SY_PIN6];
    byteIn = {q.rxSh[6:0], mosi};

    unique case (q.phase)
      // Pins stay released until the straps have passed the synchronisers
      D_WAIT: begin
        if (q.settle == STRAP_SETTLE_CNT) begin
          n.phase = D_RUN;
          if (q.filt[SY_I2CSEL]) begin
            n.link = LINK_I2C;
          end else if (q.filt[SY_EXTADDR]) begin
            n.link = LINK_SPI;
          end else begin
            n.link = LINK_UART;
          end
          // Address bits 0..5 from shared pins 6..1, bit 6 from the address pin
          n.i2cAddr = {q.filt[SY_EXTADDR], q.filt[SY_LOW], q.filt[SY_LOW+1],
                       q.filt[SY_LOW+2], q.filt[SY_LOW+3], q.filt[SY_PIN5],
                       q.filt[SY_PIN6]};
        end else begin
          n.settle = q.settle + 4'h1;
        end
      end
      // The link and address never change again before reset
      D_RUN: begin
        unique case (q.link)
          LINK_UART: begin
            n.uartRx = n.filt[SY_SDATA];
            n.p7     = uartTx;
            n.p7Oe   = 1'b1;
            n.p6     = uartAux;
            n.p6Oe   = 1'b1;
            n.p5     = uartRts;
            n.p5Oe   = 1'b1;
          end
          LINK_SPI: begin
            // SCK and MOSI are inputs only; D4..D1 are ignored
            n.p6Oe = 1'b0;
            n.p5Oe = 1'b0;
            if (!nssLow) begin
              n.bitCnt    = 3'h0;
              n.firstByte = 1'b1;
              n.p7Oe      = 1'b0;
              n.p7        = 1'b0;
              n.rdPend    = 1'b0;
              n.nextTx    = 8'h00;
            end else begin
              n.p7Oe = 1'b1;
              // Read data must stand by the edge that ends the request cycle
              if (q.rdPend) begin
                n.nextTx = rdData;
                n.rdPend = 1'b0;
              end
              if (rise) begin
                n.rxSh   = byteIn;
                n.bitCnt = q.bitCnt + 3'h1;
                if (q.bitCnt == LAST_BIT) begin
                  n.nextTx = 8'h00;
                  if (q.firstByte) begin
                    n.firstByte = 1'b0;
                    n.isRead    = byteIn[ADDR_DIR_BIT];
                    n.addr      = byteIn[ADDR_MSB:ADDR_LSB];
                    wantRead    = (byteIn[ADDR_DIR_BIT] == DIR_READ);
                  end else begin
                    wantRead = q.isRead && (byteIn != BURST_END);
                  end
                  if (wantRead) begin
                    n.rdReq  = 1'b1;
                    n.rdAddr = byteIn[ADDR_MSB:ADDR_LSB];
                    n.rdPend = 1'b1;
                  end else if (!q.firstByte && !q.isRead) begin
                    n.wrStrobe = 1'b1;
                    n.wrAddr   = q.addr;
                    n.wrData   = byteIn;
                  end
                end
              end
              // A falling edge after a full byte opens the next byte
              if (fall) begin
                if (q.bitCnt == 3'h0) begin
                  n.p7   = q.nextTx[7];
                  n.txSh = {q.nextTx[6:0], 1'b0};
                end else begin
                  n.p7   = q.txSh[7];
                  n.txSh = {q.txSh[6:0], 1'b0};
                end
              end
            end
          end
          LINK_I2C: begin
            // Protocol engine lives elsewhere; pins stay released here
            n.p7Oe = 1'b0;
            n.p6Oe = 1'b0;
            n.p5Oe = 1'b0;
          end
          LINK_NONE: begin
            n.p7Oe = 1'b0;
          end
        endcase
      end
    endcase
  end

  // Single state register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // Outputs straight from the state register
  assign linkSel        = q.link;
  assign wrStrobe       = q.wrStrobe;
  assign wrAddr         = q.wrAddr;
  assign wrData         = q.wrData;
  assign rdReq          = q.rdReq;
  assign rdAddr         = q.rdAddr;
  assign uartRx         = q.uartRx;
  assign i2cAddr        = q.i2cAddr;
  assign link.devPin7   = q.p7;
  assign link.devPin7Oe = q.p7Oe;
  assign link.devPin6   = q.p6;
  assign link.devPin6Oe = q.p6Oe;
  assign link.devPin5   = q.p5;
  assign link.devPin5Oe = q.p5Oe;
endmodule : hid_device

/* pkg/hid_pkg.sv */
package hid_pkg;
  // Clock and link timing; counts derive from the figures in ns
  localparam int CLK_FREQ_KHZ      = 25000;
  localparam int CLK_PERIOD_NS     = 1000000 / CLK_FREQ_KHZ;
  localparam int SPI_MAX_RATE_KBPS = 10000;
  localparam int SPI_MIN_HALF_NS   = 1000000 / (2 * SPI_MAX_RATE_KBPS);
  // Host half period; must not be below SPI_MIN_HALF_NS and must cover both synchronisers
  localparam int HOST_SCK_HALF_NS  = 400;
  localparam int HOST_HALF_CYC     = (HOST_SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] HOST_HALF_CNT = 8'(HOST_HALF_CYC - 1);
  // Strap settle time after reset release, a least time
  localparam int STRAP_SETTLE_NS   = 200;
  localparam int STRAP_SETTLE_CYC  = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] STRAP_SETTLE_CNT = 4'(STRAP_SETTLE_CYC);

  // Synchroniser bit positions at the device
  localparam int NSYNC      = 9;
  localparam int SY_SDATA   = 0;
  localparam int SY_I2CSEL  = 1;
  localparam int SY_EXTADDR = 2;
  localparam int SY_PIN6    = 3;
  localparam int SY_PIN5    = 4;
  localparam int SY_LOW     = 5;

  // Address byte layout
  localparam int ADDR_DIR_BIT     = 7;
  localparam int ADDR_MSB         = 6;
  localparam int ADDR_LSB         = 1;
  localparam logic DIR_READ       = 1'b1;
  localparam logic ADDR_PAD       = 1'b0;
  localparam logic [7:0] BURST_END = 8'h00;
  localparam logic [2:0] LAST_BIT  = 3'h7;

  typedef enum logic [1:0] {
    LINK_NONE,
    LINK_UART,
    LINK_SPI,
    LINK_I2C
  } hid_link_e;
endpackage : hid_pkg

/* pkg/hid_link_if.sv */
`timescale 1ns/1ps
interface hid_link_if;
  logic       hostSdata;   // Serial-data pin, NSS in SPI
  logic       i2cSel;      // Select strap
  logic       extAddr;     // external_address_pin strap
  logic [3:0] lowPins;     // Shared pins 4..1
  logic       hostPin6;    // Host drive of shared_pin_6
  logic       hostPin6Oe;  // Host enable of shared_pin_6
  logic       hostPin5;    // Host drive of shared_pin_5
  logic       hostPin5Oe;  // Host enable of shared_pin_5
  logic       devPin7;     // Device drive of shared_pin_7
  logic       devPin7Oe;   // Device enable of shared_pin_7
  logic       devPin6;     // Device drive of shared_pin_6
  logic       devPin6Oe;   // Device enable of shared_pin_6
  logic       devPin5;     // Device drive of shared_pin_5
  logic       devPin5Oe;   // Device enable of shared_pin_5
  logic       pin7;        // Resolved shared_pin_7
  logic       pin6;        // Resolved shared_pin_6
  logic       pin5;        // Resolved shared_pin_5

  // Wire levels; undriven pins rest high through a pull-up
  assign pin7 = devPin7Oe ? devPin7 : 1'b1;
  assign pin6 = devPin6Oe ? devPin6 : (hostPin6Oe ? hostPin6 : 1'b1);
  assign pin5 = devPin5Oe ? devPin5 : (hostPin5Oe ? hostPin5 : 1'b1);

  modport dev (
    input  hostSdata, i2cSel, extAddr, lowPins, pin6, pin5,
    output devPin7, devPin7Oe, devPin6, devPin6Oe, devPin5, devPin5Oe
  );
  modport host (
    output hostSdata, i2cSel, extAddr, lowPins, hostPin6, hostPin6Oe, hostPin5, hostPin5Oe,
    input  pin7
  );
endinterface : hid_link_if

/* hw/hid_host.sv */
`timescale 1ns/1ps
module hid_host (
  input  wire logic       clk,         // System clock
  input  wire logic       rst_b,       // Synchronous reset, active low
  hid_link_if.host        link,        // Pins toward the device
  input  wire logic       strapI2c,    // Select strap level
  input  wire logic       strapExt,    // Address pin strap level
  input  wire logic [3:0] strapLow,    // Shared pins 4..1 levels
  input  wire logic       cmdValid,    // Start a transfer
  output logic            cmdReady,    // Idle, command accepted
  input  wire logic       cmdRead,     // One for read burst
  input  wire logic [5:0] cmdAddr,     // Register address
  input  wire logic [7:0] cmdLen,      // Data byte count, at least one
  output logic            dataReq,     // Next write byte wanted
  input  wire logic [7:0] wrByte,      // Write byte, in the same cycle as dataReq
  output logic            rdValid,     // Read byte pulse
  output logic [7:0]      rdByte       // Read byte
);
  import hid_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE,
    H_LOW,
    H_HIGH,
    H_END,
    H_GAP
  } hid_hstate_e;

  typedef struct packed {
    hid_hstate_e state;
    logic [7:0]  cnt;
    logic [2:0]  bitCnt;
    logic [7:0]  byteIdx;
    logic [7:0]  len;
    logic        isRead;
    logic [7:0]  addrByte;
    logic [7:0]  txSh;
    logic [7:0]  rxSh;
    logic [7:0]  nextByte;
    logic        capPend;
    logic        s0;
    logic        s1;
    logic        s2;
    logic        filt;
    logic        nss;
    logic        sck;
    logic        mosi;
    logic        pinOe;
    logic        i2cSel;
    logic        extAddr;
    logic [3:0]  lowPins;
    logic        cmdReady;
    logic        dataReq;
    logic        rdValid;
    logic [7:0]  rdByte;
  } hid_host_s;

  hid_host_s q;
  hid_host_s n;

  // Next-state logic of the master
  always_comb begin
    logic [7:0] byteIn;
    logic [7:0] nb;
    byteIn = 8'h00;
    nb     = 8'h00;
    n         = q;
    n.dataReq = 1'b0;
    n.rdValid = 1'b0;
    n.pinOe   = 1'b1;
    n.i2cSel  = strapI2c;
    n.extAddr = strapExt;
    n.lowPins = strapLow;
    // MISO comes from another domain: three stages, stages two and three agree
    n.s0 = link.pin7;
    n.s1 = q.s0;
    n.s2 = q.s1;
    if (q.s1 == q.s2) begin
      n.filt = q.s2;
    end
    byteIn = {q.rxSh[6:0], q.filt};
    if (q.capPend) begin
      n.nextByte = wrByte;
      n.capPend  = 1'b0;
    end

    unique case (q.state)
      H_IDLE: begin
        if (cmdValid) begin
          n.isRead   = cmdRead;
          n.len      = cmdLen;
          n.addrByte = {cmdRead, cmdAddr, ADDR_PAD};
          n.mosi     = cmdRead;
          n.txSh     = {cmdAddr, ADDR_PAD, 1'b0};
          n.nss      = 1'b0;
          n.cnt      = 8'h00;
          n.bitCnt   = 3'h0;
          n.byteIdx  = 8'h00;
          n.state    = H_LOW;
        end
      end
      // Half period is fixed well below the rate ceiling
      H_LOW: begin
        if (q.cnt == HOST_HALF_CNT) begin
          n.cnt   = 8'h00;
          n.sck   = 1'b1;
          n.rxSh  = byteIn;
          n.state = H_HIGH;
          if (q.bitCnt == LAST_BIT) begin
            if (q.isRead && q.byteIdx != 8'h00) begin
              n.rdValid = 1'b1;
              n.rdByte  = byteIn;
            end
            if (!q.isRead && q.byteIdx < q.len) begin
              n.dataReq = 1'b1;
              n.capPend = 1'b1;
            end
          end
        end else begin
          n.cnt = q.cnt + 8'h01;
        end
      end
      // MOSI only moves together with the falling edge
      H_HIGH: begin
        if (q.cnt == HOST_HALF_CNT) begin
          n.cnt = 8'h00;
          n.sck = 1'b0;
          if (q.bitCnt == LAST_BIT) begin
            if (q.byteIdx == q.len) begin
              n.state = H_END;
            end else begin
              if (q.isRead) begin
                nb = ((q.byteIdx + 8'h01) < q.len) ? q.addrByte : BURST_END;
              end else begin
                nb = q.nextByte;
              end
              n.mosi    = nb[7];
              n.txSh    = {nb[6:0], 1'b0};
              n.byteIdx = q.byteIdx + 8'h01;
              n.bitCnt  = 3'h0;
              n.state   = H_LOW;
            end
          end else begin
            n.mosi   = q.txSh[7];
            n.txSh   = {q.txSh[6:0], 1'b0};
            n.bitCnt = q.bitCnt + 3'h1;
            n.state  = H_LOW;
          end
        end else begin
          n.cnt = q.cnt + 8'h01;
        end
      end
      H_END: begin
        if (q.cnt == HOST_HALF_CNT) begin
          n.cnt   = 8'h00;
          n.nss   = 1'b1;
          n.state = H_GAP;
        end else begin
          n.cnt = q.cnt + 8'h01;
        end
      end
      // Idle gap lets the device see NSS high before a new frame
      H_GAP: begin
        if (q.cnt == HOST_HALF_CNT) begin
          n.cnt   = 8'h00;
          n.state = H_IDLE;
        end else begin
          n.cnt = q.cnt + 8'h01;
        end
      end
      default: begin
        n.state = H_IDLE;
      end
    endcase
    n.cmdReady = (n.state == H_IDLE);
  end

  // Single state register; NSS rests high
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q     <= '0;
      q.nss <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign cmdReady        = q.cmdReady;
  assign dataReq         = q.dataReq;
  assign rdValid         = q.rdValid;
  assign rdByte          = q.rdByte;
  assign link.hostSdata  = q.nss;
  assign link.i2cSel     = q.i2cSel;
  assign link.extAddr    = q.extAddr;
  assign link.lowPins    = q.lowPins;
  assign link.hostPin6   = q.mosi;
  assign link.hostPin6Oe = q.pinOe;
  assign link.hostPin5   = q.sck;
  assign link.hostPin5Oe = q.pinOe;
endmodule : hid_host

/* dv/hid_link_assertions.sv */
`timescale 1ns/1ps
module hid_link_assertions (
  input wire logic clk,        // System clock
  input wire logic rst_b,      // Sync reset, active low
  input wire logic hostSdata,  // Serial-data pin, NSS in SPI
  input wire logic i2cSel,     // Select strap
  input wire logic extAddr,    // Address pin strap
  input wire logic hostPin6,   // Host drive of pin 6, MOSI
  input wire logic hostPin5,   // Host drive of pin 5, SCK
  input wire logic devPin7,    // Device drive of pin 7, MISO
  input wire logic devPin7Oe,  // Device enable of pin 7
  input wire logic devPin6Oe,  // Device enable of pin 6
  input wire logic devPin5Oe   // Device enable of pin 5
);
  logic [3:0] age_ff;   // Cycles since release, saturating
  logic [1:0] mode_ff;  // Early copy of the straps {select, address}
  // Straps hold still from release, so an early copy stands in for the device latch
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      age_ff  <= 4'h0;
      mode_ff <= 2'h0;
    end else begin
      if (age_ff != 4'hF) age_ff <= age_ff + 4'h1;
      if (age_ff == 4'h1) mode_ff <= {i2cSel, extAddr};
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  quiet_before_detect_a: assert property (age_ff < 4'h5 |-> !devPin7Oe && !devPin6Oe && !devPin5Oe)
    else $error("pin driven before link detection");
  no_sck_drive_a: assert property (mode_ff == 2'h1 && age_ff >= 4'h2 |-> !devPin5Oe)
    else $error("device drives serial clock");
  mosi_input_a: assert property (mode_ff == 2'h1 && age_ff >= 4'h2 |-> !devPin6Oe)
    else $error("device drives MOSI pin");
  i2c_release_a: assert property (mode_ff[1] && age_ff >= 4'h2 |-> !(devPin7Oe || devPin6Oe || devPin5Oe))
    else $error("pin driven in I2C mode");
  uart_drive_a: assert property (mode_ff == 2'h0 && age_ff == 4'hF |-> devPin7Oe && devPin5Oe)
    else $error("UART outputs not driven");
  sck_idle_a: assert property (hostSdata |-> !hostPin5)
    else $error("clock high outside frame");
  first_rise_a: assert property ($fell(hostSdata) |-> !hostPin5 [*8] ##[1:4] hostPin5)
    else $error("first clock rise misplaced");
  sck_half_a: assert property ($rose(hostPin5) |-> hostPin5 [*8])
    else $error("clock high phase too short");
  mosi_stable_a: assert property ($rose(hostPin5) |-> $stable(hostPin6))
    else $error("MOSI changed at rising edge");
  miso_low_phase_a: assert property (mode_ff == 2'h1 && age_ff >= 4'h2 && !hostSdata
      && devPin7Oe && $past(devPin7Oe) && $changed(devPin7) |-> !hostPin5)
    else $error("MISO changed while clock high");

  // Main scenarios reached
  cover property ($fell(hostSdata));
  cover property (mode_ff == 2'h0 && age_ff == 4'hF);
  cover property (mode_ff[1] && age_ff == 4'hF);
endmodule : hid_link_assertions

/* dv/host_if_detect_spi_slave_tb.sv */
`timescale 1ns/1ps
module host_if_detect_spi_slave_tb;
  import hid_pkg::*;
  logic       clk, rst_b, sI2c, sExt, cmdValid, cmdRead, uL;
  logic [3:0] sLow;
  logic [5:0] cmdAddr, wrAddr, rdAddr;
  logic [7:0] cmdLen, wrByte, rdData, wrData, rdByte;
  logic       wrStrobe, rdReq, uartRx, cmdReady, dataReq, rdValid;
  logic [6:0] i2cAddr;
  hid_link_e  linkSel;
  logic [7:0] regs [64];
  logic [7:0] wq [$];
  logic [7:0] rq [$];
  logic [13:0] wl [$];
  int rdReqs = 0;
  int fail_count = 0;
  int checks_done = 0;

  hid_link_if link ();
  hid_device hid_device_inst (.clk(clk), .rst_b(rst_b), .link(link.dev), .linkSel(linkSel),
    .wrStrobe(wrStrobe), .wrAddr(wrAddr), .wrData(wrData), .rdReq(rdReq), .rdAddr(rdAddr),
    .rdData(rdData), .uartRx(uartRx), .uartTx(uL), .uartAux(uL), .uartRts(uL),
    .i2cAddr(i2cAddr));
  hid_host hid_host_inst (.clk(clk), .rst_b(rst_b), .link(link.host), .strapI2c(sI2c),
    .strapExt(sExt), .strapLow(sLow), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdRead(cmdRead), .cmdAddr(cmdAddr), .cmdLen(cmdLen), .dataReq(dataReq),
    .wrByte(wrByte), .rdValid(rdValid), .rdByte(rdByte));
  hid_link_assertions hid_link_assertions_inst (.clk(clk), .rst_b(rst_b),
    .hostSdata(link.hostSdata), .i2cSel(link.i2cSel), .extAddr(link.extAddr),
    .hostPin6(link.hostPin6), .hostPin5(link.hostPin5), .devPin7(link.devPin7),
    .devPin7Oe(link.devPin7Oe), .devPin6Oe(link.devPin6Oe), .devPin5Oe(link.devPin5Oe));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Register file and byte sources; pulses are seen just after the edge that raised
  // them, so each answer stands before the edge that closes the pulse cycle takes it
  always @(posedge clk) begin
    #1;
    if (rdReq) begin
      rdReqs++;
      rdData = regs[rdAddr];
    end
    if (wrStrobe) begin
      wl.push_back({wrAddr, wrData});
      regs[wrAddr] = wrData;
    end
    if (dataReq) wrByte = (wq.size() > 0) ? wq.pop_front() : 8'h00;
    if (rdValid) rq.push_back(rdByte);
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    if (fail_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  // Bounded wait for the host to come back to idle
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clk) #1;
    while (cmdReady !== 1'b1) begin
      n++;
      if (n > 5000) begin
        fail_count++;
        final_report();
      end
      @(posedge clk) #1;
    end
  endtask : wait_ready

  task automatic xfer(input logic rd, input logic [5:0] a, input logic [7:0] n);
    wait_ready();
    cmdRead = rd;
    cmdAddr = a;
    cmdLen = n;
    cmdValid = 1'b1;
    @(posedge clk) #1;
    cmdValid = 1'b0;
    wait_ready();
  endtask : xfer

  // Straps are set before release and held, as the device expects
  task automatic restart(input logic i, input logic e);
    rst_b = 1'b0;
    sI2c = i;
    sExt = e;
    repeat (16) @(posedge clk) #1;
    rst_b = 1'b1;
    repeat (12) @(posedge clk) #1;
  endtask : restart

  task automatic t_detect();
    restart(1'b0, 1'b0);
    check(linkSel, LINK_UART);
    check(uartRx, 1'b1);
    uL = 1'b0;
    repeat (2) @(posedge clk) #1;
    check({link.pin7, link.pin6, link.pin5}, 3'h0);
    uL = 1'b1;
    repeat (2) @(posedge clk) #1;
    check({link.pin7, link.pin6, link.pin5}, 3'h7);
    restart(1'b1, 1'b1);
    check(linkSel, LINK_I2C);
    check(i2cAddr, 7'h64);
    restart(1'b0, 1'b1);
    check(linkSel, LINK_SPI);
  endtask : t_detect

  // Write burst then read burst back to back; the counter must restart between frames
  task automatic t_burst();
    logic [7:0] e [3];
    e = '{8'hA5, 8'h3C, 8'h81};
    wq = '{8'hA5, 8'h3C, 8'h81};
    xfer(1'b0, 6'h2A, 8'h03);
    check(wl.size(), 3);
    for (int i = 0; i < 3; i++) begin
      check(wl[i], {6'h2A, e[i]});
    end
    xfer(1'b1, 6'h2A, 8'h02);
    check(rdReqs, 2);
    check(rq[0], 8'h81);
    check(rq[1], 8'h81);
  endtask : t_burst

  // Straps moved after detection must change nothing
  task automatic t_latch();
    sI2c = 1'b1;
    sExt = 1'b0;
    repeat (20) @(posedge clk) #1;
    check(linkSel, LINK_SPI);
    wq = '{8'h5A};
    wl.delete();
    rq.delete();
    xfer(1'b0, 6'h3F, 8'h01);
    xfer(1'b1, 6'h3F, 8'h01);
    check(wl[0], {6'h3F, 8'h5A});
    check(rq[0], 8'h5A);
  endtask : t_latch

  initial begin
    rst_b = 1'b0;
    sI2c = 1'b0;
    sExt = 1'b1;
    sLow = 4'h9;
    cmdValid = 1'b0;
    cmdRead = 1'b0;
    cmdAddr = 6'h00;
    cmdLen = 8'h01;
    wrByte = 8'h00;
    rdData = 8'h00;
    uL = 1'b0;
    t_detect();
    t_burst();
    t_latch();
    final_report();
  end
endmodule : host_if_detect_spi_slave_tb
